// *** rtl/stm_cfg.svh ***
// Constants of the target message handler: codes, offsets, timing
`ifndef STM_CFG_SVH
`define STM_CFG_SVH

// ----------------------------------------------------------------
// Message codes
// ----------------------------------------------------------------
`define STM_MSG_EXT 8'h01
`define STM_MSG_DISC 8'h04
`define STM_MSG_REJ 8'h07
`define STM_MSG_BDR 8'h0C
`define STM_MSG_CONT 8'h12
`define STM_MSG_TTD 8'h13
`define STM_MSG_SIMPLE 8'h20
`define STM_MSG_HEAD 8'h21
`define STM_MSG_ORDER 8'h22
`define STM_MSG_RESID 8'h23
`define STM_ID_TX 8'h80
`define STM_RESID_ONE 8'h01

// ----------------------------------------------------------------
// Identify byte fields
// ----------------------------------------------------------------
`define STM_ID_BIT 7
`define STM_ID_DPRIV 6
`define STM_ID_LUNTAR 5

// ----------------------------------------------------------------
// Extended message codes and lengths
// ----------------------------------------------------------------
`define STM_XC_SDTR 8'h01
`define STM_XC_WDTR 8'h03
`define STM_XL_SDTR 9'h003
`define STM_XL_WDTR 9'h002
`define STM_XL_ZERO 9'h100
`define STM_OFS_UNLIM 8'hFF

// ----------------------------------------------------------------
// Register offsets and reset values
// ----------------------------------------------------------------
`define STM_REG_CTRL 2'h0
`define STM_REG_STAT 2'h1
`define STM_REG_PER 2'h2
`define STM_REG_OFS 2'h3
`define STM_CTRL_RST 1'b0

// ----------------------------------------------------------------
// Timing and queue depth
// ----------------------------------------------------------------
`define STM_CLK_PS 5000
`define STM_PF_PS 4000
`define STM_QDEPTH 4

`endif

// *** rtl/stm_pkg.sv ***
// Types of the target message handler
package stm_pkg;

   typedef enum logic [1:0] {
      RX_MSG,
      RX_TAG,
      RX_XLEN,
      RX_XBODY
   } stm_rx_t;

   typedef struct packed {
      stm_rx_t rx;
      logic [8:0] xlen;
      logic [8:0] xidx;
      logic [7:0] xcode;
      logic [7:0] xarg0;
      logic [7:0] xarg1;
      logic [1:0] qtype;
      logic disc_priv;
      logic ttd;
      logic grant;
      logic rej_pend;
      logic wait_rej;
      logic bus_free;
      logic sync_on;
      logic width16;
      logic wide_en;
      logic neg_done;
      logic [7:0] period;
      logic [7:0] offset;
      logic [3:0][7:0] tx_buf;
      logic [2:0] tx_n;
      logic tx_disc;
      logic [3:0][7:0] q_tag;
      logic [2:0] q_cnt;
      logic other_vld;
      logic [7:0] other_byte;
      logic [7:0] rdata;
   } stm_state_t;

endpackage

// *** rtl/stm_msg_handler.sv ***
// Target-side message handler: decode, tag queue, message-in sequencing
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "stm_cfg.svh"

module stm_msg_handler
   import stm_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   input wire logic bus_rst,
   // Message-out bytes from initiator, one per handshake
   input wire logic mo_valid,
   input wire logic [7:0] mo_byte,
   input wire logic atn,
   // Message-in bytes to initiator
   output logic mi_valid,
   output logic [7:0] mi_byte,
   input wire logic mi_ready,
   // Sequencer commands
   input wire logic cmd_reconnect,
   input wire logic cmd_tagged,
   input wire logic [7:0] cmd_tag,
   input wire logic cmd_disconnect,
   input wire logic cmd_residue,
   input wire logic conn_initial,
   input wire logic phase_is_data,
   input wire logic proc_end,
   // Command queue
   input wire logic q_pop,
   output logic q_valid,
   output logic [7:0] q_head_tag,
   output logic q_full,
   // Connection status
   output logic disc_allowed,
   output logic din_ok,
   output logic dout_ok,
   output logic bus_free,
   output logic xfer_sync,
   output logic [7:0] sync_offset,
   output logic offset_unlimited,
   output logic [10:0] req_gap_cycles,
   output logic width16,
   output logic neg_done,
   output logic other_vld,
   output logic [7:0] other_byte,
   // Register port
   input wire logic [1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata
);

   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   // Least gap between request edges in clock cycles, rounded up
   function automatic logic [10:0] gap_cycles(input logic [7:0] pf);
      logic [31:0] ps;
      logic [31:0] cyc;
      ps = 32'(pf) * `STM_PF_PS;
      cyc = (ps + `STM_CLK_PS - 1) / `STM_CLK_PS;
      if (cyc == 32'h0) begin
         cyc = 32'h1;
      end
      return cyc[10:0];
   endfunction

   // Identify byte with valid layout and unit number zero
   function automatic logic id_ok(input logic [7:0] b);
      return b[`STM_ID_BIT] && !b[`STM_ID_LUNTAR] && b[4:0] == 5'h00;
   endfunction

   // -------------------------------------------------------------
   // State
   // -------------------------------------------------------------
   stm_state_t st_ff;
   stm_state_t nxt_st;

   // Every register of the block lives in st_ff; the comb process
   // starts from a copy and edits only what this cycle changes.
   // Pulse outputs are cleared first so they last one cycle.

   always_comb begin
      logic [1:0] qi;
      logic last_sent;
      qi = 2'h0;
      last_sent = 1'b0;
      nxt_st = st_ff;
      nxt_st.bus_free = 1'b0;
      nxt_st.neg_done = 1'b0;
      nxt_st.other_vld = 1'b0;

      // -------------------------------------------------------------
      // Registers
      // -------------------------------------------------------------
      if (reg_wr && reg_addr == `STM_REG_CTRL) begin
         nxt_st.wide_en = reg_wdata[0];
      end
      if (reg_rd) begin
         case (reg_addr)
            `STM_REG_CTRL: nxt_st.rdata = {7'h00, st_ff.wide_en};
            `STM_REG_STAT: nxt_st.rdata = {st_ff.q_cnt, st_ff.width16,
               st_ff.grant, st_ff.ttd, st_ff.disc_priv, st_ff.sync_on};
            `STM_REG_PER: nxt_st.rdata = st_ff.period;
            `STM_REG_OFS: nxt_st.rdata = st_ff.offset;
            default: nxt_st.rdata = 8'h00;
         endcase
      end

      // -------------------------------------------------------------
      // Queue pop
      // -------------------------------------------------------------
      // Pop before push so a tag taken in the same cycle lands in
      // the slot freed by the pop
      if (q_pop && st_ff.q_cnt != 3'h0) begin
         nxt_st.q_tag = {8'h00, st_ff.q_tag[3:1]};
         nxt_st.q_cnt = st_ff.q_cnt - 3'h1;
      end

      // -------------------------------------------------------------
      // Message-out decoder
      // -------------------------------------------------------------
      if (mo_valid) begin
         case (st_ff.rx)
            RX_MSG: begin
               // First byte after a disconnect sent with attention
               // raised: a reject keeps the link, anything else
               // lets the target drop off the bus
               if (st_ff.wait_rej) begin
                  nxt_st.wait_rej = 1'b0;
                  if (mo_byte == `STM_MSG_REJ) begin
                     nxt_st.grant = st_ff.ttd;
                  end else begin
                     nxt_st.bus_free = 1'b1;
                  end
               end else if (mo_byte[`STM_ID_BIT]) begin
                  if (id_ok(mo_byte)) begin
                     nxt_st.disc_priv = mo_byte[`STM_ID_DPRIV];
                  end else begin
                     nxt_st.rej_pend = 1'b1;
                  end
               end else begin
                  case (mo_byte)
                     `STM_MSG_SIMPLE, `STM_MSG_HEAD, `STM_MSG_ORDER: begin
                        nxt_st.qtype = mo_byte[1:0];
                        nxt_st.rx = RX_TAG;
                     end
                     `STM_MSG_TTD: nxt_st.ttd = 1'b1;
                     `STM_MSG_CONT: nxt_st.grant = 1'b1;
                     `STM_MSG_EXT: nxt_st.rx = RX_XLEN;
                     // Device reset drops every agreement and the
                     // whole queue, like a bus reset
                     `STM_MSG_BDR: begin
                        nxt_st.sync_on = 1'b0;
                        nxt_st.width16 = 1'b0;
                        nxt_st.offset = 8'h00;
                        nxt_st.period = 8'h00;
                        nxt_st.ttd = 1'b0;
                        nxt_st.grant = 1'b0;
                        nxt_st.q_cnt = 3'h0;
                     end
                     `STM_MSG_REJ: nxt_st.rej_pend = 1'b1;
                     default: begin
                        nxt_st.other_vld = 1'b1;
                        nxt_st.other_byte = mo_byte;
                     end
                  endcase
               end
            end
            RX_TAG: begin
               // Tag value is kept as is and never used for ordering
               nxt_st.rx = RX_MSG;
               if (nxt_st.q_cnt == 3'(`STM_QDEPTH)) begin
                  nxt_st.rej_pend = 1'b1;
               end else if (st_ff.qtype == 2'h1) begin
                  // Head goes in front, so later heads stack LIFO
                  nxt_st.q_tag = {nxt_st.q_tag[2:0], mo_byte};
                  nxt_st.q_cnt = nxt_st.q_cnt + 3'h1;
               end else begin
                  // Simple and ordered go to the tail: FIFO order
                  qi = nxt_st.q_cnt[1:0];
                  nxt_st.q_tag[qi] = mo_byte;
                  nxt_st.q_cnt = nxt_st.q_cnt + 3'h1;
               end
            end
            RX_XLEN: begin
               nxt_st.xlen = (mo_byte == 8'h00) ? `STM_XL_ZERO
                  : {1'b0, mo_byte};
               nxt_st.xidx = 9'h000;
               nxt_st.rx = RX_XBODY;
            end
            // Body bytes: code, then arguments; only the first two
            // arguments are kept, the rest are counted and dropped
            // so long messages still end on the right byte
            RX_XBODY: begin
               case (st_ff.xidx)
                  9'h000: nxt_st.xcode = mo_byte;
                  9'h001: nxt_st.xarg0 = mo_byte;
                  9'h002: nxt_st.xarg1 = mo_byte;
                  default: nxt_st.xidx = st_ff.xidx;
               endcase
               nxt_st.xidx = st_ff.xidx + 9'h001;
               if (st_ff.xidx + 9'h001 == st_ff.xlen) begin
                  nxt_st.rx = RX_MSG;
                  if (st_ff.xcode == `STM_XC_SDTR
                     || (st_ff.xidx == 9'h000
                     && mo_byte == `STM_XC_SDTR)) begin
                     if (st_ff.xlen == `STM_XL_SDTR) begin
                        nxt_st.period = st_ff.xarg0;
                        nxt_st.offset = mo_byte;
                        nxt_st.sync_on = mo_byte != 8'h00;
                        nxt_st.neg_done = 1'b1;
                     end else begin
                        nxt_st.rej_pend = 1'b1;
                     end
                  end else if (st_ff.xcode == `STM_XC_WDTR
                     && st_ff.xlen == `STM_XL_WDTR) begin
                     nxt_st.width16 = st_ff.wide_en && mo_byte == 8'h01;
                     nxt_st.neg_done = 1'b1;
                  end else begin
                     nxt_st.rej_pend = 1'b1;
                  end
               end
            end
            default: nxt_st.rx = RX_MSG;
         endcase
      end

      // -------------------------------------------------------------
      // Message-in sequencer
      // -------------------------------------------------------------
      // Bytes leave from slot 0; the buffer shifts down on every
      // taken byte. The last byte of a disconnect sequence decides
      // between going bus free and waiting for a reject.
      // Attention is looked at only on that last byte.
      if (st_ff.tx_n != 3'h0 && mi_ready) begin
         nxt_st.tx_buf = {8'h00, st_ff.tx_buf[3:1]};
         nxt_st.tx_n = st_ff.tx_n - 3'h1;
         last_sent = st_ff.tx_n == 3'h1;
      end
      if (last_sent && st_ff.tx_disc) begin
         nxt_st.tx_disc = 1'b0;
         if (atn) begin
            nxt_st.wait_rej = 1'b1;
         end else begin
            nxt_st.bus_free = 1'b1;
         end
      end
      // New sequences start only on an empty buffer; a pending
      // reject goes first so the initiator can tell which byte
      // was refused. Commands meeting a busy buffer are dropped.
      if (nxt_st.tx_n == 3'h0) begin
         if (st_ff.rej_pend) begin
            nxt_st.rej_pend = 1'b0;
            nxt_st.tx_buf = {24'h000000, `STM_MSG_REJ};
            nxt_st.tx_n = 3'h1;
         end else if (cmd_reconnect) begin
            nxt_st.grant = 1'b0;
            nxt_st.tx_buf[0] = `STM_ID_TX;
            if (cmd_tagged) begin
               nxt_st.tx_buf[1] = `STM_MSG_SIMPLE;
               nxt_st.tx_buf[2] = cmd_tag;
               nxt_st.tx_buf[3] = `STM_MSG_DISC;
               nxt_st.tx_n = st_ff.ttd ? 3'h4 : 3'h3;
            end else begin
               nxt_st.tx_buf[1] = `STM_MSG_DISC;
               nxt_st.tx_n = st_ff.ttd ? 3'h2 : 3'h1;
            end
            nxt_st.tx_disc = st_ff.ttd;
         end else if (cmd_disconnect && st_ff.disc_priv) begin
            nxt_st.tx_buf = {24'h000000, `STM_MSG_DISC};
            nxt_st.tx_n = 3'h1;
            nxt_st.tx_disc = 1'b1;
         end else if (cmd_residue) begin
            nxt_st.tx_buf = {16'h0000, `STM_RESID_ONE,
               `STM_MSG_RESID};
            nxt_st.tx_n = 3'h2;
         end
      end

      // Clears come last so they win over same-cycle sets
      // End of the process frees its disable and grant
      if (proc_end) begin
         nxt_st.ttd = 1'b0;
         nxt_st.grant = 1'b0;
      end
      // Bus reset: back to asynchronous narrow transfer, queue
      // emptied, any message in flight abandoned
      if (bus_rst) begin
         nxt_st.sync_on = 1'b0;
         nxt_st.width16 = 1'b0;
         nxt_st.offset = 8'h00;
         nxt_st.period = 8'h00;
         nxt_st.ttd = 1'b0;
         nxt_st.grant = 1'b0;
         nxt_st.q_cnt = 3'h0;
         nxt_st.tx_n = 3'h0;
         nxt_st.rx = RX_MSG;
         nxt_st.wait_rej = 1'b0;
         nxt_st.rej_pend = 1'b0;
      end
   end

   // -------------------------------------------------------------
   // State register
   // -------------------------------------------------------------
   // Power-on state is all zero: asynchronous, no disable, empty
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // -------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------
   // Handshake flags decode the state; data come straight from
   // flip-flops, so nothing combinational reaches the bus bytes
   // Permission levels follow disable and grant of the process
   assign mi_valid = st_ff.tx_n != 3'h0;
   assign mi_byte = st_ff.tx_buf[0];
   assign q_valid = st_ff.q_cnt != 3'h0;
   assign q_head_tag = st_ff.q_tag[0];
   assign q_full = st_ff.q_cnt == 3'(`STM_QDEPTH);
   assign disc_allowed = st_ff.disc_priv;
   assign din_ok = !st_ff.ttd || st_ff.grant;
   assign dout_ok = !st_ff.ttd || conn_initial
      || st_ff.grant;
   assign bus_free = st_ff.bus_free;
   assign xfer_sync = st_ff.sync_on && phase_is_data;
   assign sync_offset = st_ff.offset;
   assign offset_unlimited = st_ff.offset == `STM_OFS_UNLIM;
   assign req_gap_cycles = gap_cycles(st_ff.period);
   assign width16 = st_ff.width16;
   assign neg_done = st_ff.neg_done;
   assign other_vld = st_ff.other_vld;
   assign other_byte = st_ff.other_byte;
   assign reg_rdata = st_ff.rdata;

endmodule

// *** verification/stm_init_model.sv ***
// Initiator-side partner model: takes and records message-in bytes
`timescale 1ns/1ps
module stm_init_model (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Message-in handshake
   input wire logic mi_valid,
   input wire logic [7:0] mi_byte,
   output logic mi_ready,
   // Stall on alternate cycles when set
   input wire logic slow
);
   // ------------------------------------------------------------
   // Receive side
   // ------------------------------------------------------------
   logic [7:0] rx_q_ff [0:15];
   int rx_n_ff;
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mi_ready <= 1'b0;
         rx_n_ff <= 0;
      end else begin
         mi_ready <= slow ? !mi_ready : 1'b1;
         if (mi_valid && mi_ready) begin
            rx_q_ff[rx_n_ff[3:0]] <= mi_byte;
            rx_n_ff <= rx_n_ff + 1;
         end
      end
   end
endmodule

// *** verification/stm_msg_handler_assertions.sv ***
// Port assertions of the target message handler
`timescale 1ns/1ps
module stm_msg_handler_assertions (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   input wire logic bus_rst,
   // Handshakes and commands
   input wire logic mo_valid,
   input wire logic mi_valid,
   input wire logic [7:0] mi_byte,
   input wire logic mi_ready,
   input wire logic cmd_reconnect,
   input wire logic cmd_disconnect,
   input wire logic cmd_residue,
   input wire logic phase_is_data,
   // Status
   input wire logic disc_allowed,
   input wire logic din_ok,
   input wire logic dout_ok,
   input wire logic bus_free,
   input wire logic xfer_sync,
   input wire logic [7:0] sync_offset,
   input wire logic offset_unlimited
);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   logic quiet;
   // Transmitter idle and nothing competing for it
   assign quiet = !mi_valid && !mo_valid && !bus_rst;
   a_resid_first: assert property (
      cmd_residue && !cmd_reconnect && !cmd_disconnect && quiet
      |=> mi_valid && mi_byte == 8'h23) else $error("residue not sent");
   a_ident_tx: assert property (
      cmd_reconnect && !cmd_residue && !cmd_disconnect && quiet
      |=> mi_valid && mi_byte == 8'h80) else $error("identify not 80h");
   a_priv_disc: assert property (
      cmd_disconnect && !disc_allowed && !cmd_reconnect && !cmd_residue
      && quiet |=> !mi_valid) else $error("disconnect without privilege");
   a_sync_data: assert property (xfer_sync |-> phase_is_data)
      else $error("sync outside data phase");
   a_unlim_ofs: assert property (
      offset_unlimited |-> sync_offset == 8'hFF) else $error("bad unlimited");
   a_rst_void: assert property (bus_rst |=> !xfer_sync
      && sync_offset == 8'h00) else $error("agreement kept over reset");
   a_din_dout: assert property (din_ok |-> dout_ok)
      else $error("data-in allowed without data-out");
   a_mi_hold: assert property (
      mi_valid && !mi_ready && !bus_rst |=> mi_valid && $stable(mi_byte))
      else $error("message-in byte dropped");
   c_free: cover property (bus_free);
   c_stall: cover property (mi_valid && !mi_ready);
   c_sync: cover property (xfer_sync);
endmodule

bind stm_msg_handler stm_msg_handler_assertions u_chk (.clk, .arst_n,
   .bus_rst, .mo_valid, .mi_valid, .mi_byte, .mi_ready, .cmd_reconnect,
   .cmd_disconnect, .cmd_residue, .phase_is_data, .disc_allowed, .din_ok,
   .dout_ok, .bus_free, .xfer_sync, .sync_offset, .offset_unlimited);

// *** verification/stm_msg_handler_tb_top.sv ***
// Self-checking bench of the target message handler
`timescale 1ns/1ps
module stm_msg_handler_tb_top;
   import stm_pkg::*;
   // ------------------------------------------------------------
   // Stimulus, partner and scenarios
   // ------------------------------------------------------------
   logic clk = 1'b0, arst_n = 1'b0, bus_rst = 1'b0, mo_valid = 1'b0;
   logic atn = 1'b0, cmd_tagged = 1'b1, conn_initial = 1'b0, slow = 1'b0;
   logic phase_is_data = 1'b0, proc_end = 1'b0, q_pop = 1'b0;
   logic reg_wr = 1'b0, reg_rd = 1'b0;
   logic [1:0] reg_addr = 2'h0;
   logic [2:0] cmd = 3'h0;
   logic [7:0] mo_byte = 8'h00, cmd_tag = 8'h00, reg_wdata = 8'h00;
   logic cmd_reconnect, cmd_disconnect, cmd_residue, mi_valid, mi_ready;
   logic q_valid, q_full, disc_allowed, din_ok, dout_ok, bus_free;
   logic xfer_sync, offset_unlimited, width16, neg_done, other_vld;
   logic [7:0] mi_byte, q_head_tag, sync_offset, other_byte, reg_rdata;
   logic [10:0] req_gap_cycles;
   int fails = 0, total_checks = 0, free_n = 0, neg_n = 0;
   assign {cmd_residue, cmd_disconnect, cmd_reconnect} = cmd;
   always #2.5 clk = ~clk;
   always @(posedge clk) begin
      if (bus_free === 1'b1) free_n <= free_n + 1;
      if (neg_done === 1'b1) neg_n <= neg_n + 1;
   end
   stm_msg_handler u_dut (.clk, .arst_n, .bus_rst, .mo_valid, .mo_byte, .atn,
      .mi_valid, .mi_byte, .mi_ready, .cmd_reconnect, .cmd_tagged, .cmd_tag,
      .cmd_disconnect, .cmd_residue, .conn_initial, .phase_is_data, .proc_end,
      .q_pop, .q_valid, .q_head_tag, .q_full, .disc_allowed, .din_ok, .dout_ok,
      .bus_free, .xfer_sync, .sync_offset, .offset_unlimited, .req_gap_cycles,
      .width16, .neg_done, .other_vld, .other_byte, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata);
   stm_init_model u_init (.clk, .arst_n, .mi_valid, .mi_byte, .mi_ready,
      .slow);
   task automatic print_verdict;
      if (fails == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] s, e);
      total_checks++;
      if (s !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask
   function automatic logic [7:0] rx(input int i);
      return u_init.rx_q_ff[i[3:0]];
   endfunction
   // Holds valid between bytes; idle lowers it
   task automatic mo(input logic [7:0] b);
      mo_valid <= 1'b1;
      mo_byte <= b;
      @(posedge clk);
   endtask
   task automatic idle(input int n);
      mo_valid <= 1'b0;
      repeat (n) @(posedge clk);
   endtask
   task automatic send(input logic [7:0] b [$]);
      foreach (b[i]) mo(b[i]);
      idle(2);
   endtask
   task automatic fire(input logic [2:0] c);
      cmd <= c;
      @(posedge clk);
      cmd <= 3'h0;
   endtask
   task automatic wait_rx(input int n);
      for (int i = 0; i < 300; i++) begin
         if (u_init.rx_n_ff >= n) return;
         @(posedge clk);
      end
      fails++;
      print_verdict();
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] v);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a, output logic [7:0] d);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      d = reg_rdata;
   endtask
   task automatic t_reset;
      logic [7:0] d;
      chk("din_ok", din_ok, 1'b1);
      chk("gap", req_gap_cycles, 11'h001);
      wr(2'h1, 8'hFF);
      for (int a = 0; a < 4; a++) begin
         rd(a[1:0], d);
         chk("reg", d, 8'h00);
      end
   endtask
   task automatic t_sync;
      logic [7:0] d;
      int n;
      n = neg_n;
      send('{8'h01, 8'h03, 8'h01, 8'h33, 8'h08});
      chk("neg_done", neg_n - n, 1);
      chk("offset", sync_offset, 8'h08);
      chk("gap", req_gap_cycles, 11'h029);
      chk("sync_ctl", xfer_sync, 1'b0);
      phase_is_data <= 1'b1;
      @(posedge clk);
      chk("sync_dat", xfer_sync, 1'b1);
      rd(2'h2, d);
      chk("period", d, 8'h33);
      send('{8'h01, 8'h03, 8'h01, 8'h19, 8'hFF});
      chk("unlim", offset_unlimited, 1'b1);
      send('{8'h01, 8'h03, 8'h01, 8'h19, 8'h00});
      chk("async", xfer_sync, 1'b0);
      send('{8'h01, 8'h03, 8'h01, 8'h33, 8'h08});
      bus_rst <= 1'b1;
      @(posedge clk);
      bus_rst <= 1'b0;
      repeat (2) @(posedge clk);
      chk("rst_sync", xfer_sync, 1'b0);
      phase_is_data <= 1'b0;
      wr(2'h0, 8'h01);
      send('{8'h01, 8'h02, 8'h03, 8'h01});
      chk("wide", width16, 1'b1);
   endtask
   task automatic t_reject;
      logic [7:0] codes [9] = '{8'h00, 8'h02, 8'h04, 8'h7F, 8'h80, 8'hFF,
         8'hA0, 8'h81, 8'h88};
      int n;
      foreach (codes[i]) begin
         n = u_init.rx_n_ff;
         if (i < 6) send('{8'h01, 8'h01, codes[i]});
         else send('{codes[i]});
         wait_rx(n + 1);
         chk("reject", rx(n), 8'h07);
      end
      send('{8'hC0});
      n = u_init.rx_n_ff;
      mo(8'h01);
      mo(8'h00);
      mo(8'h02);
      repeat (255) mo(8'h80);
      idle(2);
      wait_rx(n + 1);
      chk("body", disc_allowed, 1'b1);
      chk("rej_len0", rx(n), 8'h07);
      send('{8'h80});
      chk("end", disc_allowed, 1'b0);
   endtask
   task automatic t_queue;
      logic [7:0] exp [4] = '{8'hD4, 8'hC3, 8'hFF, 8'hB2};
      int n;
      send('{8'h80, 8'h20, 8'hFF});
      send('{8'h80, 8'h22, 8'hB2});
      send('{8'h80, 8'h21, 8'hC3});
      send('{8'h80, 8'h21, 8'hD4});
      chk("q_full", q_full, 1'b1);
      n = u_init.rx_n_ff;
      send('{8'h80, 8'h20, 8'h00});
      wait_rx(n + 1);
      chk("q_rej", rx(n), 8'h07);
      foreach (exp[i]) begin
         chk("q_head", q_head_tag, exp[i]);
         q_pop <= 1'b1;
         @(posedge clk);
         q_pop <= 1'b0;
         @(posedge clk);
      end
      chk("q_empty", q_valid, 1'b0);
   endtask
   task automatic t_ttd;
      int n;
      int f;
      conn_initial <= 1'b1;
      send('{8'hC0, 8'h13});
      chk("din_init", din_ok, 1'b0);
      chk("dout_init", dout_ok, 1'b1);
      conn_initial <= 1'b0;
      repeat (2) @(posedge clk);
      chk("dout_re", dout_ok, 1'b0);
      slow <= 1'b1;
      n = u_init.rx_n_ff;
      f = free_n;
      cmd_tag <= 8'h5A;
      fire(3'h1);
      wait_rx(n + 4);
      idle(3);
      chk("id", rx(n), 8'h80);
      chk("tag_msg", rx(n + 1), 8'h20);
      chk("tag", rx(n + 2), 8'h5A);
      chk("disc", rx(n + 3), 8'h04);
      chk("free", free_n - f, 1);
      atn <= 1'b1;
      fire(3'h1);
      wait_rx(n + 8);
      send('{8'h07});
      chk("din_grant", din_ok, 1'b1);
      chk("kept", free_n - f, 1);
      atn <= 1'b0;
      slow <= 1'b0;
      proc_end <= 1'b1;
      @(posedge clk);
      proc_end <= 1'b0;
   endtask
   task automatic t_disc;
      int n;
      int f;
      n = u_init.rx_n_ff;
      f = free_n;
      send('{8'h80});
      fire(3'h2);
      idle(4);
      chk("ignored", u_init.rx_n_ff - n, 0);
      send('{8'hC0});
      chk("priv", disc_allowed, 1'b1);
      fire(3'h2);
      wait_rx(n + 1);
      idle(3);
      chk("disc", rx(n), 8'h04);
      chk("free", free_n - f, 1);
      fire(3'h4);
      wait_rx(n + 3);
      chk("resid", rx(n + 1), 8'h23);
      chk("resid_n", rx(n + 2), 8'h01);
   endtask
   initial begin
      repeat (20) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      t_reset();
      t_sync();
      t_reject();
      t_queue();
      t_ttd();
      t_disc();
      print_verdict();
   end
endmodule
